// [ccp_core.sv]
// How it works
// - Each instruction is one 14-bit word
// - One full word fetched each instruction cycle
// - Next fetch overlaps current execution
// - One cycle per instruction, branches take two
// - 2K or 4K words of internal program store
// - Special registers and counter live in file space
// - 8-bit ALU: add, subtract, shift, logic
// - Arithmetic is two's complement
// - Two operands: accumulator with file or literal
// - One operand: accumulator or file register
// - Accumulator is 8-bit and not addressable
// - ALU updates carry, half carry, zero flags
// - Subtraction carries hold inverted borrows
// - Clock divided into four phases per cycle
// - Counter increments every phase one
// - Fetched word latched at phase four
// - Latched word executes in the next cycle
// - RC mode outputs quarter-rate cycle clock
// - Low master clear resets the core
// - Operand read phase two, written phase four
// - Counter change flushes the fetched word
// - Start at 0000h, interrupts enter at 0004h
`timescale 1ns/100ps
`default_nettype none
module ccp_core
  import ccp_pkg::*;
#(
  parameter bit LARGE_MEM = 1'b1 // 4K store when set, 2K otherwise
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic master_clear_n_in,
  input wire logic rc_osc_mode_in,
  input wire logic irq_in,
  input wire ccp_load_t load_in,
  output logic osc_out,
  output ccp_state_t state_out
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Add with carry in; returns {carry, half carry, sum}
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return {full[8], low[4], full[7:0]};
  endfunction : add8

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] mclr_sync; // Master clear stages
  logic [2:0] rc_sync; // Oscillator mode stages
  logic mclr_level; // Filtered master clear
  logic rc_mode; // Filtered RC mode
  logic core_rst; // Core reset, active high

  // Three stages; accept once the last two agree
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      mclr_sync <= 3'h0;
      rc_sync <= 3'h0;
      mclr_level <= 1'b0;
      rc_mode <= 1'b0;
    end else begin
      mclr_sync <= {mclr_sync[1:0], master_clear_n_in};
      rc_sync <= {rc_sync[1:0], rc_osc_mode_in};
      if (mclr_sync[1] == mclr_sync[2]) mclr_level <= mclr_sync[2];
      if (rc_sync[1] == rc_sync[2]) rc_mode <= rc_sync[2];
    end
  end

  assign core_rst = !rstn_in || !mclr_level;

  // ----------------------------------------
  // Phase generator
  // ----------------------------------------
  ccp_phase_t phase; // Current quarter of the cycle

  // Four phases in turn, parked at phase one in reset
  always_ff @(posedge clk_in) begin
    if (core_rst) begin
      phase <= CCP_P1;
    end else begin
      unique case (phase)
        CCP_P1: phase <= CCP_P2;
        CCP_P2: phase <= CCP_P3;
        CCP_P3: phase <= CCP_P4;
        CCP_P4: phase <= CCP_P1;
      endcase
    end
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [13:0] pmem [CCP_PMEM_DEPTH]; // Program store
  logic [7:0] dmem [CCP_DMEM_DEPTH]; // General file registers
  logic [12:0] stack [CCP_STACK_DEPTH]; // Return addresses
  logic [2:0] sp; // Stack pointer, wraps
  logic [12:0] pc; // prog_counter
  logic [12:0] fetch_addr; // Address being fetched
  logic [13:0] instr_reg; // Word under execution
  logic ir_valid; // Word is live, not flushed
  logic [7:0] acc; // accumulator_reg, no file address
  logic [7:0] status; // Flags
  logic [7:0] fsel; // Indirect pointer
  logic [4:0] pc_high; // Upper counter latch
  logic [7:0] operand; // File operand read in phase two
  logic gie; // Interrupt enable
  logic [12:0] pmask; // Variant wrap mask

  assign pmask = LARGE_MEM ? CCP_MASK_LARGE : CCP_MASK_SMALL;

  // Program loading, internal store only
  always_ff @(posedge clk_in) begin
    if (load_in.en) pmem[load_in.addr] <= load_in.data;
  end

  // ----------------------------------------
  // Decode and execute
  // ----------------------------------------
  logic [6:0] faddr; // Effective file address
  logic [1:0] cls; // Instruction class
  logic [3:0] op; // Byte opcode
  logic dbit; // Destination select
  logic [7:0] lit; // Literal field
  logic [7:0] bmask; // Bit select mask
  logic [7:0] res; // Result
  logic [9:0] sum; // Adder output
  logic wr_f, wr_w, upd_c, upd_dc, upd_z; // Write and flag enables
  logic new_c, new_dc; // Flag values
  logic jump, push, pop, skip, retint; // Flow controls
  logic [12:0] target; // Jump target
  logic pcl_write; // Counter written through file space
  logic take_irq; // Interrupt accepted
  logic flush; // Drop word fetched this cycle

  assign cls = instr_reg[13:12];
  assign op = instr_reg[11:8];
  assign dbit = instr_reg[7];
  assign lit = instr_reg[7:0];
  assign bmask = 8'h01 << instr_reg[9:7];
  assign faddr = (instr_reg[6:0] == CCP_A_INDIRECT) ? fsel[6:0] : instr_reg[6:0];

  // One instruction worth of results, applied at phase four
  always_comb begin
    res = operand;
    sum = 10'h000;
    {wr_f, wr_w, upd_c, upd_dc, upd_z, new_c, new_dc} = 7'h00;
    {jump, push, pop, skip, retint} = 5'h00;
    target = stack[sp - 3'h1];
    unique case (cls)
      CCP_C_BYTE: begin
        wr_f = dbit;
        wr_w = !dbit;
        upd_z = 1'b1;
        unique case (op)
          CCP_O_MISC: begin
            wr_w = 1'b0;
            upd_z = 1'b0;
            res = acc;
            if (!dbit && instr_reg[6:0] == CCP_X_RETURN) begin
              {jump, pop} = 2'h3;
            end else if (!dbit && instr_reg[6:0] == CCP_X_RETINT) begin
              {jump, pop, retint} = 3'h7;
            end
          end
          CCP_O_CLR: res = 8'h00;
          CCP_O_SUB: begin
            sum = add8(operand, ~acc, 1'b1);
            {new_c, new_dc, res} = sum;
            {upd_c, upd_dc} = 2'h3;
          end
          CCP_O_DEC: res = operand - 8'h01;
          CCP_O_IOR: res = operand | acc;
          CCP_O_AND: res = operand & acc;
          CCP_O_XOR: res = operand ^ acc;
          CCP_O_ADD: begin
            sum = add8(operand, acc, 1'b0);
            {new_c, new_dc, res} = sum;
            {upd_c, upd_dc} = 2'h3;
          end
          CCP_O_MOV: res = operand;
          CCP_O_COM: res = ~operand;
          CCP_O_INC: res = operand + 8'h01;
          CCP_O_DECSKP: begin
            res = operand - 8'h01;
            upd_z = 1'b0;
            skip = (res == 8'h00);
          end
          CCP_O_RRC: begin
            res = {status[CCP_B_CARRY], operand[7:1]};
            {upd_c, new_c, upd_z} = {1'b1, operand[0], 1'b0};
          end
          CCP_O_RLC: begin
            res = {operand[6:0], status[CCP_B_CARRY]};
            {upd_c, new_c, upd_z} = {1'b1, operand[7], 1'b0};
          end
          CCP_O_SWAP: begin
            res = {operand[3:0], operand[7:4]};
            upd_z = 1'b0;
          end
          CCP_O_INCSKP: begin
            res = operand + 8'h01;
            upd_z = 1'b0;
            skip = (res == 8'h00);
          end
        endcase
      end
      CCP_C_BIT: begin
        unique case (instr_reg[11:10])
          2'h0: {res, wr_f} = {operand & ~bmask, 1'b1};
          2'h1: {res, wr_f} = {operand | bmask, 1'b1};
          2'h2: skip = ((operand & bmask) == 8'h00);
          2'h3: skip = ((operand & bmask) != 8'h00);
        endcase
      end
      CCP_C_JUMP: begin
        jump = 1'b1;
        push = !instr_reg[11];
        target = {pc_high[4:3], instr_reg[10:0]};
      end
      CCP_C_LIT: begin
        wr_w = 1'b1;
        upd_z = 1'b1;
        if (op[3:2] == 2'h0) begin
          {res, upd_z} = {lit, 1'b0};
        end else if (op[3:2] == 2'h1) begin
          {res, upd_z, jump, pop} = {lit, 3'h3};
        end else if (op == 4'h8) begin
          res = lit | acc;
        end else if (op == 4'h9) begin
          res = lit & acc;
        end else if (op == 4'ha) begin
          res = lit ^ acc;
        end else begin
          sum = add8(lit, op[1] ? acc : ~acc, !op[1]);
          {new_c, new_dc, res} = sum;
          {upd_c, upd_dc} = 2'h3;
        end
      end
    endcase
    if (!ir_valid) begin
      {wr_f, wr_w, upd_c, upd_dc, upd_z, jump, push, pop, skip, retint} = 10'h000;
    end
  end

  assign pcl_write = wr_f && faddr == CCP_A_PCLOW;
  assign take_irq = irq_in && gie && !jump && !pcl_write;
  assign flush = jump || skip || pcl_write || take_irq;

  // ----------------------------------------
  // Counter, fetch and pipeline
  // ----------------------------------------
  // Count at phase one, redirect and latch at phase four
  always_ff @(posedge clk_in) begin
    if (core_rst) begin
      pc <= CCP_RESET_VEC;
      fetch_addr <= CCP_RESET_VEC;
      instr_reg <= 14'h0000;
      ir_valid <= 1'b0;
    end else if (phase == CCP_P1) begin
      fetch_addr <= pc & pmask;
      pc <= pc + 13'h0001;
    end else if (phase == CCP_P4) begin
      instr_reg <= pmem[fetch_addr[11:0]];
      ir_valid <= !flush;
      if (take_irq) pc <= CCP_IRQ_VEC;
      else if (pcl_write) pc <= {pc_high, res};
      else if (jump) pc <= target;
    end
  end

  // Return stack
  always_ff @(posedge clk_in) begin
    if (core_rst) begin
      sp <= 3'h0;
    end else if (phase == CCP_P4) begin
      if (push || take_irq) begin
        stack[sp] <= fetch_addr;
        sp <= sp + 3'h1;
      end else if (pop) begin
        sp <= sp - 3'h1;
      end
    end
  end

  // Interrupt enable
  always_ff @(posedge clk_in) begin
    if (core_rst) gie <= 1'b0;
    else if (phase == CCP_P4 && take_irq) gie <= 1'b0;
    else if (phase == CCP_P4 && retint) gie <= 1'b1;
  end

  // ----------------------------------------
  // Operand read and destination write
  // ----------------------------------------
  // Operand fetched from file space in phase two
  always_ff @(posedge clk_in) begin
    if (core_rst) begin
      operand <= 8'h00;
    end else if (phase == CCP_P2) begin
      unique case (faddr)
        CCP_A_PCLOW: operand <= fetch_addr[7:0];
        CCP_A_STATUS: operand <= status;
        CCP_A_FSEL: operand <= fsel;
        CCP_A_PCHIGH: operand <= {3'h0, pc_high};
        default: operand <= (faddr == CCP_A_INDIRECT) ? 8'h00 : dmem[faddr];
      endcase
    end
  end

  // Destination written in phase four
  always_ff @(posedge clk_in) begin
    if (core_rst) begin
      acc <= 8'h00;
      fsel <= 8'h00;
      pc_high <= 5'h00;
    end else if (phase == CCP_P4) begin
      if (wr_w) acc <= res;
      if (wr_f && faddr == CCP_A_FSEL) fsel <= res;
      if (wr_f && faddr == CCP_A_PCHIGH) pc_high <= res[4:0];
    end
  end

  // General file registers
  always_ff @(posedge clk_in) begin
    if (!core_rst && phase == CCP_P4 && wr_f && faddr > CCP_A_FSEL && faddr != CCP_A_PCHIGH) begin
      dmem[faddr] <= res;
    end
  end

  // Status: flag updates override a direct write
  always_ff @(posedge clk_in) begin
    if (core_rst) begin
      status <= CCP_STATUS_RST;
    end else if (phase == CCP_P4) begin
      if (wr_f && faddr == CCP_A_STATUS) status <= res;
      if (upd_c) status[CCP_B_CARRY] <= new_c;
      if (upd_dc) status[CCP_B_HALF] <= new_dc;
      if (upd_z) status[CCP_B_ZERO] <= (res == 8'h00);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Quarter-rate clock, high during phases three and four
  always_ff @(posedge clk_in) begin
    if (core_rst) osc_out <= 1'b0;
    else osc_out <= rc_mode && (phase == CCP_P2 || phase == CCP_P3);
  end

  // Observed core state, one clock behind
  always_ff @(posedge clk_in) begin
    if (!rstn_in) state_out <= '0;
    else state_out <= '{pc, acc, status, instr_reg, ir_valid, phase == CCP_P1};
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (core_rst);

  chk_phase_order: assert property (phase == CCP_P1 |=> phase == CCP_P2 ##1 phase == CCP_P3 ##1 phase == CCP_P4)
    else $error("phase sequence broken");
  chk_pc_step: assert property (phase == CCP_P1 |=> pc == $past(pc) + 13'h0001)
    else $error("counter did not step in phase one");
  chk_ir_hold: assert property (phase != CCP_P4 |=> $stable(instr_reg))
    else $error("instruction latched outside phase four");
  chk_acc_write: assert property (phase != CCP_P4 |=> $stable(acc) && $stable(status))
    else $error("destination written outside phase four");
  chk_branch_flush: assert property (phase == CCP_P4 && jump |=> !ir_valid ##4 (ir_valid || $past(take_irq)))
    else $error("branch did not flush exactly one word");
  chk_zero_flag: assert property (phase == CCP_P4 && upd_z |=> status[CCP_B_ZERO] == ($past(res) == 8'h00))
    else $error("zero flag wrong");
  chk_sub_borrow: assert property (phase == CCP_P4 && ir_valid && cls == CCP_C_BYTE && op == CCP_O_SUB
      |=> status[CCP_B_CARRY] == ($past(operand) >= $past(acc)))
    else $error("borrow flag wrong");
  chk_cycle_clock_out_rate: assert property (rc_mode && phase == CCP_P2 |=> osc_out ##1 osc_out ##1 !osc_out)
    else $error("cycle clock wrong");
  chk_reset_start: assert property (phase == CCP_P1 && $past(core_rst) |-> pc == CCP_RESET_VEC && !ir_valid)
    else $error("restart not clean");
  cov_branch: cover property (phase == CCP_P4 && jump && push);
  cov_skip: cover property (phase == CCP_P4 && skip);
  cov_irq: cover property (phase == CCP_P4 && take_irq);

endmodule : ccp_core
`default_nettype wire

// [ccp_pkg.sv]
`default_nettype none
package ccp_pkg;

  // ----------------------------------------
  // Widths and sizes
  // ----------------------------------------
  localparam int CCP_IW = 14; // Instruction word width
  localparam int CCP_PW = 13; // Program counter width
  localparam int CCP_PMEM_DEPTH = 4096; // Largest program store
  localparam int CCP_DMEM_DEPTH = 128; // File register space
  localparam int CCP_STACK_DEPTH = 8; // Return stack levels
  localparam logic [12:0] CCP_MASK_SMALL = 13'h07ff; // 2K wrap
  localparam logic [12:0] CCP_MASK_LARGE = 13'h0fff; // 4K wrap
  localparam logic [12:0] CCP_RESET_VEC = 13'h0000; // Start address
  localparam logic [12:0] CCP_IRQ_VEC = 13'h0004; // Interrupt entry

  // ----------------------------------------
  // Special file addresses
  // ----------------------------------------
  localparam logic [6:0] CCP_A_INDIRECT = 7'h00; // Indirect access
  localparam logic [6:0] CCP_A_PCLOW = 7'h02; // Low counter byte
  localparam logic [6:0] CCP_A_STATUS = 7'h03; // Flags
  localparam logic [6:0] CCP_A_FSEL = 7'h04; // Indirect pointer
  localparam logic [6:0] CCP_A_PCHIGH = 7'h0a; // Upper counter latch

  // ----------------------------------------
  // Status bit positions and reset value
  // ----------------------------------------
  localparam int CCP_B_CARRY = 0; // carry_flag
  localparam int CCP_B_HALF = 1; // half_carry_flag
  localparam int CCP_B_ZERO = 2; // zero_flag
  localparam logic [7:0] CCP_STATUS_RST = 8'h18; // Status at reset

  // ----------------------------------------
  // Instruction classes and opcodes
  // ----------------------------------------
  localparam logic [1:0] CCP_C_BYTE = 2'h0; // File register ops
  localparam logic [1:0] CCP_C_BIT = 2'h1; // Bit ops
  localparam logic [1:0] CCP_C_JUMP = 2'h2; // Call and jump
  localparam logic [1:0] CCP_C_LIT = 2'h3; // Literal ops
  localparam logic [6:0] CCP_X_RETURN = 7'h08; // Return in misc group
  localparam logic [6:0] CCP_X_RETINT = 7'h09; // Return from interrupt
  localparam logic [3:0] CCP_O_MISC = 4'h0, CCP_O_CLR = 4'h1, CCP_O_SUB = 4'h2, CCP_O_DEC = 4'h3;
  localparam logic [3:0] CCP_O_IOR = 4'h4, CCP_O_AND = 4'h5, CCP_O_XOR = 4'h6, CCP_O_ADD = 4'h7;
  localparam logic [3:0] CCP_O_MOV = 4'h8, CCP_O_COM = 4'h9, CCP_O_INC = 4'ha, CCP_O_DECSKP = 4'hb;
  localparam logic [3:0] CCP_O_RRC = 4'hc, CCP_O_RLC = 4'hd, CCP_O_SWAP = 4'he, CCP_O_INCSKP = 4'hf;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {CCP_P1, CCP_P2, CCP_P3, CCP_P4} ccp_phase_t; // Clock phases

  typedef struct packed {
    logic en; // Write strobe
    logic [11:0] addr; // Word address
    logic [13:0] data; // Instruction word
  } ccp_load_t;

  typedef struct packed {
    logic [12:0] pc; // prog_counter
    logic [7:0] acc; // accumulator_reg
    logic [7:0] status; // Status register
    logic [13:0] ir; // instr_reg
    logic ir_valid; // Pipeline holds a live instruction
    logic phase_1; // Phase one marker
  } ccp_state_t;

endpackage : ccp_pkg
`default_nettype wire

// [ccp_core_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module ccp_core_tb;
  import ccp_pkg::*;

  // --------
  // Signals
  // --------
  logic clk_in; // Core clock
  logic rstn_in; // Bench reset
  logic master_clear_n_in; // Master clear pin
  logic rc_osc_mode_in; // RC mode strap
  logic irq_in; // Interrupt request, raised only in the interrupt test
  ccp_load_t load_in; // Program store writes
  logic osc_out; // Cycle clock pin
  ccp_state_t state_out; // Core snapshot
  int errors; // Mismatch count
  int checks_done; // Comparison count
  logic [13:0] prog [0:4]; // Program image
  ccp_state_t snap [$]; // One snapshot per clock
  logic osc_log [$]; // Cycle clock pin per clock
  ccp_state_t cyc [$]; // Phase one snapshots from first live word
  int cyc_at [$]; // Clock index of each phase one snapshot

  ccp_core #(.LARGE_MEM(1'b1)) i_ccp_core (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .master_clear_n_in(master_clear_n_in),
    .rc_osc_mode_in(rc_osc_mode_in),
    .irq_in(irq_in),
    .load_in(load_in),
    .osc_out(osc_out),
    .state_out(state_out)
  );

  // Free running clock, 8 ns
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // Compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Verdict and stop
  task automatic end_sim;
    $display("Checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // Hold master clear, load the image, release and record 64 clocks
  task automatic run_prog(input int straight);
    master_clear_n_in = 1'b0;
    // A nop behind the image keeps the flushed slot after the last word defined
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_in);
      #1 load_in = '{1'b1, 12'(i), (i < 5) ? prog[i] : 14'h0000};
    end
    @(posedge clk_in);
    #1 load_in = '0;
    repeat (6) @(posedge clk_in);
    #1;
    check("reset pc", 16'(state_out.pc), 16'(CCP_RESET_VEC));
    check("reset valid", 16'(state_out.ir_valid), 16'h0000);
    check("reset acc", 16'(state_out.acc), 16'h0000);
    check("reset status", 16'(state_out.status), 16'(CCP_STATUS_RST));
    master_clear_n_in = 1'b1;
    snap.delete();
    osc_log.delete();
    cyc.delete();
    cyc_at.delete();
    for (int t = 0; t < 64; t++) begin
      @(posedge clk_in);
      #1;
      snap.push_back(state_out);
      osc_log.push_back(osc_out);
      // Start at the first cycle that executes a live word
      if (state_out.phase_1 === 1'b1 && (cyc.size() > 0 || state_out.ir_valid === 1'b1)) begin
        cyc.push_back(state_out);
        cyc_at.push_back(t);
      end
    end
    check("cycles seen", 16'(cyc.size() > 5), 16'h0001);
    check("first word", 16'(cyc[0].ir), 16'(prog[0]));
    for (int k = 1; k < cyc.size(); k++) begin
      check("cycle length", 16'(cyc_at[k] - cyc_at[k-1]), 16'h0004);
    end
    for (int k = 1; k < straight; k++) begin
      check("pc step", 16'(cyc[k].pc - cyc[k-1].pc), 16'h0001);
    end
  endtask : run_prog

  // Four words then a jump to self, judge final accumulator and flags
  task automatic alu(input logic [13:0] w0, w1, w2, w3, input logic [7:0] ea, input logic [2:0] ef);
    prog[0] = w0;
    prog[1] = w1;
    prog[2] = w2;
    prog[3] = w3;
    prog[4] = 14'h2804;
    run_prog(4);
    check("acc", 16'(snap[63].acc), 16'(ea));
    check("flags", 16'(snap[63].status[2:0]), 16'(ef));
  endtask : alu

  // --------
  // Scenarios
  // --------
  // Addition with file and literal, result timing
  task automatic t_arith;
    alu(14'h300f, 14'h00a0, 14'h3001, 14'h0720, 8'h10, 3'b010);
    check("acc before write", 16'(snap[cyc_at[0] + 3].acc), 16'h0000);
    check("acc old in cycle", 16'(cyc[0].acc), 16'h0000);
    check("acc next cycle", 16'(cyc[1].acc), 16'h000f);
    alu(14'h30ff, 14'h3e01, 14'h0000, 14'h0000, 8'h00, 3'b111);
  endtask : t_arith

  // Subtraction borrows, inverted
  task automatic t_subtract;
    alu(14'h3006, 14'h3c05, 14'h0000, 14'h0000, 8'hff, 3'b000);
    alu(14'h3001, 14'h3c10, 14'h0000, 14'h0000, 8'h0f, 3'b001);
    alu(14'h3005, 14'h00a0, 14'h3005, 14'h0220, 8'h00, 3'b111);
  endtask : t_subtract

  // Boolean, rotate and complement
  task automatic t_logic;
    alu(14'h30f0, 14'h393c, 14'h3801, 14'h3a31, 8'h00, 3'b100);
    alu(14'h3081, 14'h00a0, 14'h0d20, 14'h0000, 8'h02, 3'b001);
    alu(14'h305a, 14'h00a0, 14'h0920, 14'h0000, 8'ha5, 3'b000);
  endtask : t_logic

  // Jump flushes the word behind it
  task automatic t_branch;
    prog[0] = 14'h2803;
    prog[1] = 14'h30aa;
    prog[2] = 14'h30bb;
    prog[3] = 14'h3055;
    prog[4] = 14'h2804;
    run_prog(1);
    check("flushed slot", 16'(cyc[1].ir_valid), 16'h0000);
    check("target word", 16'(cyc[2].ir), 16'h3055);
    check("target valid", 16'(cyc[2].ir_valid), 16'h0001);
    check("branch acc", 16'(snap[63].acc), 16'h0055);
  endtask : t_branch

  // Return from interrupt enables it, pending request then enters the vector
  task automatic t_irq;
    prog[0] = 14'h2002;
    prog[1] = 14'h3077;
    prog[2] = 14'h0009;
    prog[3] = 14'h0000;
    prog[4] = 14'h2804;
    irq_in = 1'b1;
    run_prog(1);
    irq_in = 1'b0;
    check("irq vector", 16'(cyc[4].pc), 16'(CCP_IRQ_VEC));
    check("irq slot", 16'(cyc[4].ir_valid), 16'h0000);
    check("irq acc", 16'(snap[63].acc), 16'h0000);
    check("vector word", 16'(snap[63].ir), 16'h2804);
  endtask : t_irq

  // Cycle clock pin in and out of RC mode
  task automatic t_osc;
    int j;
    int highs;
    prog = '{14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h2804};
    rc_osc_mode_in = 1'b1;
    run_prog(4);
    for (int k = 0; k < cyc.size() - 1; k++) begin
      j = cyc_at[k];
      check("cycle clock", 16'({osc_log[j], osc_log[j+1], osc_log[j+2], osc_log[j+3]}), 16'h0006);
    end
    rc_osc_mode_in = 1'b0;
    run_prog(4);
    highs = 0;
    foreach (osc_log[i]) begin
      highs += int'(osc_log[i] !== 1'b0);
    end
    check("pin quiet", 16'(highs), 16'h0000);
  endtask : t_osc

  // --------
  // Main sequence
  // --------
  initial begin
    errors = 0;
    checks_done = 0;
    rstn_in = 1'b0;
    master_clear_n_in = 1'b0;
    rc_osc_mode_in = 1'b0;
    irq_in = 1'b0;
    load_in = '0;
    repeat (20) @(posedge clk_in);
    #1 rstn_in = 1'b1;
    t_arith();
    t_subtract();
    t_logic();
    t_branch();
    t_irq();
    t_osc();
    end_sim();
  end

  // Watchdog, far beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    $display("Error watchdog expected finish seen hang");
    end_sim();
  end

endmodule : ccp_core_tb
`default_nettype wire
